/* File: alu_params.svh */
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define ALU_DATA_W 8
`define ALU_PROD_W 16
`define ALU_ALL_ONES 8'hFF
`define ALU_ONE 8'h01
`define ALU_ZERO 8'h00
`define ALU_ACC_RST 8'h00
`define ALU_RESULT_RST 8'h00

`endif

/* File: alu_pkg.sv */
package alu_pkg;

  // Operation select from the decoder
  typedef enum logic [3:0] {
    ALU_OP_DEC = 4'h0,
    ALU_OP_DECC = 4'h1,
    ALU_OP_AND = 4'h2,
    ALU_OP_OR = 4'h3,
    ALU_OP_XOR = 4'h4,
    ALU_OP_ADD = 4'h5,
    ALU_OP_ADDC = 4'h6,
    ALU_OP_SUBD = 4'h7,
    ALU_OP_SUBDC = 4'h8,
    ALU_OP_SUBS = 4'h9,
    ALU_OP_SUBSC = 4'hA,
    ALU_OP_MUL = 4'hB
  } alu_op_t;

  // Where the second operand comes from
  typedef enum logic [1:0] {
    ALU_SRC_REG = 2'h0,
    ALU_SRC_IMM = 2'h1,
    ALU_SRC_MEM = 2'h2
  } alu_src_t;

  typedef struct packed {
    alu_op_t op;
    alu_src_t src;
    logic [3:0] dst_sel;
    logic [7:0] opa;
    logic [7:0] reg_b;
    logic [7:0] imm;
  } alu_req_t;

  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic ovf;
    logic zero;
    logic wr_carry;
    logic wr_ovf;
    logic [7:0] hi;
    logic use_hi;
  } alu_res_t;

  typedef enum logic [1:0] {
    ALU_ST_IDLE = 2'b01,
    ALU_ST_MEM = 2'b10
  } alu_state_t;

endpackage : alu_pkg

/* File: alu_logic_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"

module alu_logic_unit (
  input wire logic [1:0] sel,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] y
);

  // 0 and, 1 or, 2 xor
  always_comb begin
    if (sel == 2'h0) begin
      y = a & b;
    end else if (sel == 2'h1) begin
      y = a | b;
    end else begin
      y = a ^ b;
    end
  end

endmodule : alu_logic_unit
`default_nettype wire

/* File: alu_mul_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"

module alu_mul_unit (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [15:0] p
);

  always_comb begin
    p = {8'h00, a} * {8'h00, b};
  end

endmodule : alu_mul_unit
`default_nettype wire

/* File: alu_core.sv */
// Summary of operation
// - Decrement subtracts one; carry clear if result is FF, else set.
// - Memory decrement reads data memory byte, same result and carry rule.
// - Decrement with borrow subtracts 1-C; carry clear only on FF with C=0.
// - AND writes destination and accumulator, changes zero flag only.
// - AND with memory combines register and data memory byte.
// - OR writes result; carry and overflow untouched.
// - XOR writes result; only zero flag affected.
// - Add sets carry on unsigned eight-bit overflow, clears otherwise.
// - Add with carry includes incoming carry; same carry rule.
// - Reverse subtract is operand minus register; carry is inverted borrow.
// - Two-register reverse subtract is second minus first, into first.
// - Reverse subtract with borrow also subtracts 1-C; carry set unless underflow.
// - Straight subtract is register minus immediate; carry clear on underflow.
// - Three-register straight subtract is second minus third, into first.
// - Straight subtract with borrow also subtracts 1-C; carry clear on underflow.
// - Straight subtract with memory is register minus data memory byte.
// - Multiply: low product byte to accumulator, high byte to destination.
// - Arithmetic sets overflow on signed overflow or underflow.
`timescale 1ns/1ps
`default_nettype none
`include "alu_params.svh"

module alu_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire alu_pkg::alu_req_t req,
  input wire logic carry_in,
  input wire logic ovf_in,
  input wire logic zero_in,
  output logic mem_rd_r,
  input wire logic mem_rd_valid,
  input wire logic [7:0] data_memory_rdata,
  output logic busy_r,
  output logic done_r,
  output logic [3:0] dst_sel_r,
  output logic [7:0] dst_data_r,
  output logic [7:0] acc_r,
  output logic carry_r,
  output logic ovf_r,
  output logic zero_r
);

  alu_pkg::alu_state_t state_r;
  alu_pkg::alu_state_t state_nxt;
  alu_pkg::alu_req_t hold_r;
  alu_pkg::alu_req_t hold_nxt;
  logic mem_rd_nxt;
  logic busy_nxt;
  logic done_nxt;
  logic [3:0] dst_sel_nxt;
  logic [7:0] dst_data_nxt;
  logic [7:0] acc_nxt;
  logic carry_nxt;
  logic ovf_nxt;
  logic zero_nxt;

  alu_pkg::alu_req_t cur;
  logic [7:0] opb;
  logic fire;
  logic [7:0] log_y;
  logic [15:0] prod;
  logic [1:0] log_sel;
  alu_pkg::alu_res_t res;
  logic [7:0] dsrc;

  // Minuend minus subtrahend minus borrow; returns {no_borrow, signed_ovf, diff}
  function automatic logic [9:0] sub_f(input logic [7:0] m, input logic [7:0] s, input logic bw);
    logic [8:0] d;
    logic v;
    d = {1'b0, m} - {1'b0, s} - {8'h00, bw};
    v = (m[7] != s[7]) && (d[7] != m[7]);
    return {~d[8], v, d[7:0]};
  endfunction : sub_f

  // Sum with carry in; returns {carry_out, signed_ovf, sum}
  function automatic logic [9:0] add_f(input logic [7:0] x, input logic [7:0] y, input logic ci);
    logic [8:0] s;
    logic v;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    v = (x[7] == y[7]) && (s[7] != x[7]);
    return {s[8], v, s[7:0]};
  endfunction : add_f

  // Borrow term, one minus carry, for the borrowing forms
  function automatic logic borrow_f(input logic c);
    return ~c;
  endfunction : borrow_f

  alu_logic_unit u_logic (
    .sel(log_sel),
    .a(cur.opa),
    .b(opb),
    .y(log_y)
  );

  alu_mul_unit u_mul (
    .a(cur.opa),
    .b(opb),
    .p(prod)
  );

  // Request in flight: a fresh one, or a held memory-operand one
  always_comb begin
    if (state_r == alu_pkg::ALU_ST_MEM) begin
      cur = hold_r;
    end else begin
      cur = req;
    end
  end

  always_comb begin
    if (cur.src == alu_pkg::ALU_SRC_MEM) begin
      opb = data_memory_rdata;
    end else if (cur.src == alu_pkg::ALU_SRC_IMM) begin
      opb = cur.imm;
    end else begin
      opb = cur.reg_b;
    end
  end

  always_comb begin
    if (cur.op == alu_pkg::ALU_OP_AND) begin
      log_sel = 2'h0;
    end else if (cur.op == alu_pkg::ALU_OP_OR) begin
      log_sel = 2'h1;
    end else begin
      log_sel = 2'h2;
    end
  end

  // Decrement source is the memory byte when the operand is memory
  always_comb begin
    if (cur.src == alu_pkg::ALU_SRC_MEM) begin
      dsrc = data_memory_rdata;
    end else begin
      dsrc = cur.opa;
    end
  end

  // Result and flag computation
  always_comb begin
    logic [9:0] t;
    t = 10'h000;
    res = '0;
    case (cur.op)
      alu_pkg::ALU_OP_DEC: begin
        t = sub_f(dsrc, `ALU_ONE, 1'b0);
        res.value = t[7:0];
        res.carry = (t[7:0] != `ALU_ALL_ONES);
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_DECC: begin
        t = sub_f(dsrc, `ALU_ZERO, borrow_f(carry_in));
        res.value = t[7:0];
        res.carry = !((t[7:0] == `ALU_ALL_ONES) && !carry_in);
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_AND: begin
        // logic ops leave carry and overflow
        res.value = log_y;
      end
      alu_pkg::ALU_OP_OR: begin
        res.value = log_y;
      end
      alu_pkg::ALU_OP_XOR: begin
        res.value = log_y;
      end
      alu_pkg::ALU_OP_ADD: begin
        t = add_f(cur.opa, opb, 1'b0);
        res.value = t[7:0];
        res.carry = t[9];
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_ADDC: begin
        t = add_f(cur.opa, opb, carry_in);
        res.value = t[7:0];
        res.carry = t[9];
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_SUBD: begin
        t = sub_f(opb, cur.opa, 1'b0);
        res.value = t[7:0];
        res.carry = t[9];
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_SUBDC: begin
        t = sub_f(opb, cur.opa, borrow_f(carry_in));
        res.value = t[7:0];
        res.carry = t[9];
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_SUBS: begin
        t = sub_f(cur.opa, opb, 1'b0);
        res.value = t[7:0];
        res.carry = t[9];
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_SUBSC: begin
        t = sub_f(cur.opa, opb, borrow_f(carry_in));
        res.value = t[7:0];
        res.carry = t[9];
        res.ovf = t[8];
        res.wr_carry = 1'b1;
        res.wr_ovf = 1'b1;
      end
      alu_pkg::ALU_OP_MUL: begin
        res.value = prod[7:0];
        res.hi = prod[15:8];
        res.use_hi = 1'b1;
      end
      default: begin
        res.value = `ALU_ZERO;
      end
    endcase
    res.zero = (res.value == `ALU_ZERO);
  end

  // Memory operand waits for its byte
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    mem_rd_nxt = 1'b0;
    fire = 1'b0;
    case (state_r)
      alu_pkg::ALU_ST_IDLE: begin
        if (req_valid && (req.src == alu_pkg::ALU_SRC_MEM)) begin
          hold_nxt = req;
          mem_rd_nxt = 1'b1;
          state_nxt = alu_pkg::ALU_ST_MEM;
        end else if (req_valid) begin
          fire = 1'b1;
        end
      end
      alu_pkg::ALU_ST_MEM: begin
        if (mem_rd_valid) begin
          fire = 1'b1;
          state_nxt = alu_pkg::ALU_ST_IDLE;
        end
      end
      default: begin
        state_nxt = alu_pkg::ALU_ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt == alu_pkg::ALU_ST_MEM);
    done_nxt = fire;
  end

  // Write back destination and accumulator
  always_comb begin
    dst_sel_nxt = dst_sel_r;
    dst_data_nxt = dst_data_r;
    acc_nxt = acc_r;
    if (fire) begin
      dst_sel_nxt = cur.dst_sel;
      if (res.use_hi) begin
        dst_data_nxt = res.hi;
      end else begin
        dst_data_nxt = res.value;
      end
      acc_nxt = res.value;
    end
  end

  // Flags: arithmetic writes carry and overflow, others pass the incoming ones; zero follows the result except multiply passes zero_in
  always_comb begin
    carry_nxt = carry_r;
    ovf_nxt = ovf_r;
    zero_nxt = zero_r;
    if (fire) begin
      if (res.wr_carry) begin
        carry_nxt = res.carry;
      end else begin
        carry_nxt = carry_in;
      end
      if (res.wr_ovf) begin
        ovf_nxt = res.ovf;
      end else begin
        ovf_nxt = ovf_in;
      end
      if (res.use_hi) begin
        zero_nxt = zero_in;
      end else begin
        zero_nxt = res.zero;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= alu_pkg::ALU_ST_IDLE;
      hold_r <= '0;
      mem_rd_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      mem_rd_r <= mem_rd_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dst_sel_r <= 4'h0;
      dst_data_r <= `ALU_RESULT_RST;
      acc_r <= `ALU_ACC_RST;
    end else begin
      dst_sel_r <= dst_sel_nxt;
      dst_data_r <= dst_data_nxt;
      acc_r <= acc_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      carry_r <= 1'b0;
      ovf_r <= 1'b0;
      zero_r <= 1'b0;
    end else begin
      carry_r <= carry_nxt;
      ovf_r <= ovf_nxt;
      zero_r <= zero_nxt;
    end
  end

endmodule : alu_core
`default_nettype wire

/* File: alu_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_core_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire alu_pkg::alu_req_t req,
  input wire logic carry_in,
  input wire logic ovf_in,
  input wire logic mem_rd_r,
  input wire logic mem_rd_valid,
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic [3:0] dst_sel_r,
  input wire logic [7:0] dst_data_r,
  input wire logic [7:0] acc_r,
  input wire logic carry_r,
  input wire logic ovf_r,
  input wire logic zero_r
);
  logic take;
  logic fast;
  logic regop;
  logic [3:0] sel_in;
  logic [8:0] sum;
  logic [15:0] prod;
  assign take = req_valid && !busy_r;
  assign fast = take && req.src != alu_pkg::ALU_SRC_MEM;
  assign regop = take && req.src == alu_pkg::ALU_SRC_REG;
  assign sel_in = req.dst_sel;
  assign sum = {1'h0, req.opa} + {1'h0, req.reg_b};
  assign prod = {8'h00, req.opa} * {8'h00, req.reg_b};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_mem_take;
    take && req.src == alu_pkg::ALU_SRC_MEM;
  endsequence
  sequence s_mem_arrive;
    busy_r && mem_rd_valid;
  endsequence
  a_reg_done: assert property (fast |=> done_r && !mem_rd_r && !busy_r)
    else $error("register op did not finish in one cycle");
  a_mem_req: assert property (s_mem_take |=> mem_rd_r && busy_r && !done_r)
    else $error("memory op did not issue a read");
  a_mem_done: assert property (s_mem_arrive |=> done_r && !busy_r)
    else $error("memory op did not finish after byte");
  a_busy_hold: assert property (busy_r && !mem_rd_valid |=> busy_r && !done_r)
    else $error("busy dropped without memory byte");
  a_zero_flag: assert property (fast && req.op != alu_pkg::ALU_OP_MUL |=> zero_r == (acc_r == 8'h00))
    else $error("zero flag disagrees with result");
  a_logic_flags: assert property (fast && req.op inside {alu_pkg::ALU_OP_AND, alu_pkg::ALU_OP_OR,
    alu_pkg::ALU_OP_XOR} |=> carry_r == $past(carry_in) && ovf_r == $past(ovf_in))
    else $error("logic op changed carry or overflow");
  a_mul_prod: assert property (regop && req.op == alu_pkg::ALU_OP_MUL |=> {dst_data_r, acc_r} == $past(prod))
    else $error("product bytes wrong");
  a_add_carry: assert property (regop && req.op == alu_pkg::ALU_OP_ADD |=> {carry_r, acc_r} == $past(sum))
    else $error("sum or carry wrong");
  a_dst_sel: assert property (fast |=> dst_sel_r == $past(sel_in))
    else $error("destination select wrong");
  a_dst_copy: assert property (fast && req.op != alu_pkg::ALU_OP_MUL |=> dst_data_r == acc_r)
    else $error("destination differs from accumulator");
endmodule : alu_core_assertions
bind alu_core alu_core_assertions u_chk (.mclk, .rst, .req_valid, .req, .carry_in, .ovf_in, .mem_rd_r,
  .mem_rd_valid, .busy_r, .done_r, .dst_sel_r, .dst_data_r, .acc_r, .carry_r, .ovf_r, .zero_r);
`default_nettype wire

/* File: alu_dmem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_dmem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rd,
  input wire logic [7:0] byte_in,
  output logic vld,
  output logic [7:0] rdata
);
  int cnt = -1;
  logic [7:0] last = 8'h00;
  // Latency 0..3; idle data is the inverse of the last byte
  always @(posedge mclk) begin
    vld <= 1'h0;
    rdata <= ~last;
    if (rst)
      cnt <= -1;
    else if (rd)
      cnt <= $urandom % 4;
    else if (cnt == 0) begin
      vld <= 1'h1;
      rdata <= byte_in;
      last <= byte_in;
      cnt <= -1;
    end else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule : alu_dmem_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst, req_valid, carry_in, ovf_in, zero_in, mem_rd_valid;
  logic mem_rd_r, busy_r, done_r, carry_r, ovf_r, zero_r;
  logic [3:0] dst_sel_r;
  logic [7:0] data_memory_rdata, dst_data_r, acc_r, mem_byte, a, b;
  logic [7:0] k[4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  alu_pkg::alu_req_t req;
  alu_pkg::alu_op_t op;
  alu_pkg::alu_src_t src;
  logic [22:0] expq[$];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  alu_core u_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req), .carry_in(carry_in),
    .ovf_in(ovf_in), .zero_in(zero_in), .mem_rd_r(mem_rd_r), .mem_rd_valid(mem_rd_valid),
    .data_memory_rdata(data_memory_rdata), .busy_r(busy_r), .done_r(done_r), .dst_sel_r(dst_sel_r),
    .dst_data_r(dst_data_r), .acc_r(acc_r), .carry_r(carry_r), .ovf_r(ovf_r), .zero_r(zero_r));
  alu_dmem_model u_mem (.mclk(mclk), .rst(rst), .rd(mem_rd_r), .byte_in(mem_byte), .vld(mem_rd_valid),
    .rdata(data_memory_rdata));
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Result bytes and flags: {dst, acc, carry, ovf, zero}
  function automatic logic [18:0] model(input alu_pkg::alu_op_t o, input logic [7:0] p, input logic [7:0] q,
                                        input logic c, input logic v, input logic z);
    logic [8:0] r;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] l;
    logic dec;
    logic rev;
    logic w;
    dec = o inside {alu_pkg::ALU_OP_DEC, alu_pkg::ALU_OP_DECC};
    rev = o inside {alu_pkg::ALU_OP_SUBD, alu_pkg::ALU_OP_SUBDC};
    x = (dec || rev) ? q : p;
    y = dec ? 8'h00 : rev ? p : q;
    w = (o == alu_pkg::ALU_OP_DEC) | (~c & (o inside {alu_pkg::ALU_OP_DECC, alu_pkg::ALU_OP_SUBDC,
        alu_pkg::ALU_OP_SUBSC}));
    r = {1'h0, x} - {1'h0, y} - {8'h00, w};
    l = o == alu_pkg::ALU_OP_AND ? p & q : o == alu_pkg::ALU_OP_OR ? p | q : p ^ q;
    if (o inside {alu_pkg::ALU_OP_AND, alu_pkg::ALU_OP_OR, alu_pkg::ALU_OP_XOR})
      return {l, l, c, v, l == 8'h00};
    if (o == alu_pkg::ALU_OP_MUL)
      return {{8'h00, p} * {8'h00, q}, c, v, z};
    if (o inside {alu_pkg::ALU_OP_ADD, alu_pkg::ALU_OP_ADDC}) begin
      r = {1'h0, p} + {1'h0, q} + {8'h00, o == alu_pkg::ALU_OP_ADDC && c};
      return {r[7:0], r[7:0], r[8], p[7] == q[7] && r[7] != p[7], r[7:0] == 8'h00};
    end
    return {r[7:0], r[7:0], ~r[8], x[7] != y[7] && r[7] != x[7], r[7:0] == 8'h00};
  endfunction : model
  task automatic send(input alu_pkg::alu_op_t o, input alu_pkg::alu_src_t s, input logic [7:0] p,
                      input logic [7:0] q, input logic c, input logic hold);
    alu_pkg::alu_req_t r;
    logic v;
    logic z;
    v = 1'($urandom);
    z = 1'($urandom);
    r.op = o;
    r.src = s;
    r.dst_sel = 4'($urandom);
    r.opa = p;
    r.reg_b = s == alu_pkg::ALU_SRC_REG ? q : ~q;
    r.imm = s == alu_pkg::ALU_SRC_IMM ? q : ~q;
    @(posedge mclk);
    req_valid <= 1'h1;
    req <= r;
    carry_in <= c;
    ovf_in <= v;
    zero_in <= z;
    mem_byte <= q;
    expq.push_back({r.dst_sel, model(o, p, q, c, v, z)});
    if (hold && s != alu_pkg::ALU_SRC_MEM)
      return;
    @(posedge mclk);
    req_valid <= hold;
    req.opa <= ~p;
    if (hold) begin
      @(negedge mclk);
      chk("busy", 23'h1, {22'h0, busy_r});
      @(posedge mclk);
      req_valid <= 1'h0;
    end
    for (int t = 0; t < 12 && expq.size() != 0; t++)
      @(negedge mclk);
  endtask : send
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      chk("timeout", 23'h0, 23'h1);
      print_verdict();
    end
  end
  always @(negedge mclk) if (done_r === 1'h1) begin
    if (expq.size() == 0)
      chk("spurious_done", 23'h0, 23'h1);
    else
      chk("result", expq.pop_front(), {dst_sel_r, dst_data_r, acc_r, carry_r, ovf_r, zero_r});
  end
  initial begin
    rst = 1'h1;
    req_valid = 1'h0;
    req = '0;
    carry_in = 1'h0;
    ovf_in = 1'h0;
    zero_in = 1'h0;
    mem_byte = 8'h00;
    void'($urandom(48530));
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk("reset_out", 23'h0, {dst_sel_r, dst_data_r, acc_r, carry_r, ovf_r, zero_r});
    chk("reset_ctl", 23'h0, {20'h0, mem_rd_r, busy_r, done_r});
    @(posedge mclk);
    rst <= 1'h0;
    foreach (k[i])
      for (int o = 0; o < 24; o++)
        send(alu_pkg::alu_op_t'(o % 12), alu_pkg::ALU_SRC_REG, k[i], k[i], 1'(o / 12), 1'h0);
    for (int i = 0; i < 300; i++) begin
      op = alu_pkg::alu_op_t'($urandom % 12);
      src = alu_pkg::alu_src_t'($urandom % 3);
      a = 8'($urandom);
      b = 8'($urandom);
      if (op inside {alu_pkg::ALU_OP_DEC, alu_pkg::ALU_OP_DECC} && src != alu_pkg::ALU_SRC_MEM) begin
        src = alu_pkg::ALU_SRC_REG;
        b = a;
      end
      send(op, src, a, b, 1'($urandom), 1'($urandom));
    end
    @(posedge mclk);
    req_valid <= 1'h0;
    repeat (4) @(negedge mclk);
    chk("drain", 23'h0, 23'(expq.size()));
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
